/* wdt_control.sv */
// Watchdog control: control status, reset cause flags, mode and actions
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Power-on flag cleared only by writing zero
// - Time-out in interrupt mode sets flag bit 7
// - Taking the vector clears the flag
// - Writing one clears flag, zero keeps it
// - Request needs flag, enable bit 6, global enable
// - Vector in combined mode clears enable and flag
// - Combined mode, unserved flag, next time-out resets
// - Reset and interrupt enable bits pick mode
// - Programmed fuse forces system reset mode
// - Clearing reset or select needs window bit 4
// - Window bit self-clears four clocks after write
// - Dog cause flag forces reset enable bit 3
// - Select is bit 5 over bits 2:0
// - Period is 2048 shifted by select code
// - Reset vector 0x0000, interrupt vector 0x0006
// - Counter counts oscillator, restart instruction clears it
// - Dog reset sets cause flag, zero write clears
// - Dog reset pulse lasts one clock
module wdt_control #(
	parameter int unsigned            BASE_TICKS = wdt_pkg::BASE_TICKS_DEFAULT
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire wdt_pkg::wdt_io_req_t io_req,
	output logic [7:0]                io_rdata,
	input  wire logic                 osc_in,
	input  wire logic                 dog_restart,
	input  wire logic                 always_on_fuse,
	input  wire logic                 global_irq_enable,
	input  wire logic                 irq_taken,
	output logic                      irq_request,
	output logic [15:0]               irq_vector,
	output logic                      dog_reset_pulse,
	output logic [15:0]               restart_vector
);
	import wdt_pkg::*;

	// Every check in this module runs on the system clock, idle in reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Whole state of the block
	typedef struct packed {
		logic       osc_s1;    // Oscillator sync stage one
		logic       osc_s2;    // Oscillator sync stage two
		logic       osc_s3;    // Edge history
		logic       fuse_s1;   // Fuse sync stage one
		logic       fuse_s2;   // Fuse sync stage two
		logic       irq_flag;  // Time-out interrupt flag
		logic       irq_en;    // Time-out interrupt enable
		logic       re;        // Stored time-out reset enable
		logic [3:0] sel;       // Time-out select
		logic       cwe;       // Change window enable
		logic [1:0] cwe_cnt;   // Cycles left in the window
		logic       por_flag;  // Power-on cause flag
		logic       dog_flag;  // Dog reset cause flag
		logic       dog_reset; // Reset pulse
		logic [7:0] rdata;     // Read data
	} wdt_ctl_state_t;

	localparam wdt_ctl_state_t ST_RESET = '{
		por_flag: POR_RESET,
		fuse_s1:  FUSE_RESET,
		fuse_s2:  FUSE_RESET,
		default:  '0
	};

	wdt_ctl_state_t s;          // Registered state
	wdt_ctl_state_t next_s;     // Next state
	logic           tick;       // One oscillator rising edge
	logic           expire;     // Counter expiry pulse
	logic           fuse_prog;  // Fuse programmed
	logic           re_eff;     // Reset enable as seen and acted on
	logic           ie_eff;     // Interrupt enable as seen and acted on
	wdt_mode_t      mode;       // Current mode
	logic           wr_csr;     // Write to control status
	logic           wr_cause;   // Write to reset cause register
	logic [7:0]     csr_view;   // Control status read value
	logic [7:0]     cause_view; // Reset cause read value

	// Address match, shared by read and write decoding
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// Mode from fuse and the two enables
	function automatic wdt_mode_t mode_of(input logic prog, input logic re,
			input logic ie);
		if (prog) begin
			return MODE_RESET;
		end
		case ({re, ie})
			2'b00:   return MODE_STOPPED;
			2'b01:   return MODE_IRQ;
			2'b10:   return MODE_RESET;
			default: return MODE_BOTH;
		endcase
	endfunction

	// Derived views of the stored bits
	always_comb begin
		fuse_prog = ~s.fuse_s2;
		// Cause flag holds reset enable on so a failing boot keeps resetting
		re_eff = fuse_prog | s.re | s.dog_flag;
		ie_eff = ~fuse_prog & s.irq_en;
		mode = mode_of(fuse_prog, re_eff, ie_eff);
		// Rising edge of the synchronised oscillator, once per cycle
		tick = s.osc_s2 & ~s.osc_s3;
		wr_csr = io_req.write & hit(io_req.addr, CSR_ADDR);
		wr_cause = io_req.write & hit(io_req.addr, CAUSE_ADDR);
		csr_view = {s.irq_flag, ie_eff, s.sel[3], s.cwe, re_eff,
			s.sel[2:0]};
		cause_view = 8'h00;
		cause_view[POR_BIT] = s.por_flag;
		cause_view[DOG_BIT] = s.dog_flag;
	end

	// Next-state logic; later assignments override earlier ones
	always_comb begin
		next_s = s;
		next_s.osc_s1 = osc_in;
		next_s.osc_s2 = s.osc_s1;
		next_s.osc_s3 = s.osc_s2;
		next_s.fuse_s1 = always_on_fuse;
		next_s.fuse_s2 = s.fuse_s1;
		next_s.dog_reset = 1'b0;
		// Window countdown
		if (s.cwe) begin
			if (s.cwe_cnt == 2'h0) begin
				next_s.cwe = 1'b0;
			end else begin
				next_s.cwe_cnt = s.cwe_cnt - 2'h1;
			end
		end
		// Software write to control status
		if (wr_csr) begin
			if (io_req.wdata[IRQ_FLAG_BIT]) begin
				next_s.irq_flag = 1'b0;
			end
			next_s.irq_en = io_req.wdata[IRQ_EN_BIT];
			if (s.cwe) begin
				// Window open: reset enable and select may change freely
				next_s.re = io_req.wdata[RE_BIT];
				next_s.sel = {io_req.wdata[SEL_HI_BIT],
					io_req.wdata[SEL_LO_MSB:0]};
			end else begin
				// Window shut: reset enable may only be set
				next_s.re = s.re | io_req.wdata[RE_BIT];
			end
			// Opening needs window and reset enable written together
			if (io_req.wdata[CWE_BIT] && io_req.wdata[RE_BIT]) begin
				next_s.cwe = 1'b1;
				next_s.cwe_cnt = CWE_LOAD;
			end else begin
				next_s.cwe = 1'b0;
			end
		end
		// Reset cause register: writing zero clears a flag
		if (wr_cause) begin
			if (!io_req.wdata[POR_BIT]) begin
				next_s.por_flag = 1'b0;
			end
			if (!io_req.wdata[DOG_BIT]) begin
				next_s.dog_flag = 1'b0;
			end
		end
		// Core takes the time-out vector
		if (irq_taken) begin
			next_s.irq_flag = 1'b0;
			if (mode == MODE_BOTH) begin
				next_s.irq_en = 1'b0;
			end
		end
		// Expiry action; sets come last so they beat any clear
		if (expire) begin
			case (mode)
				MODE_IRQ: begin
					next_s.irq_flag = 1'b1;
				end
				MODE_BOTH: begin
					if (s.irq_flag) begin
						next_s.dog_reset = 1'b1;
					end else begin
						next_s.irq_flag = 1'b1;
					end
				end
				MODE_RESET: begin
					next_s.dog_reset = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// Dog reset returns control status to its reset value
		if (next_s.dog_reset) begin
			{next_s.irq_flag, next_s.irq_en, next_s.sel[3], next_s.cwe,
				next_s.re, next_s.sel[2:0]} = CSR_RESET;
			next_s.dog_flag = 1'b1;
		end
		// Registered read data; unmapped addresses read zero
		if (io_req.read) begin
			if (hit(io_req.addr, CSR_ADDR)) begin
				next_s.rdata = csr_view;
			end else if (hit(io_req.addr, CAUSE_ADDR)) begin
				next_s.rdata = cause_view;
			end else begin
				next_s.rdata = 8'h00;
			end
		end
	end

	// State register; power-on reset sets the power-on flag and the fuse sync stages
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Period counter; restarted by the instruction and by our own reset
	wdt_timeout_counter #(
		.CW         (CNT_W),
		.BASE_TICKS (CNT_W'(BASE_TICKS))
	) u_counter (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.tick    (tick),
		.restart (dog_restart | s.dog_reset),
		.run     (mode != MODE_STOPPED),
		.select  (s.sel),
		.expire  (expire)
	);

	// Outputs
	assign io_rdata = s.rdata;
	assign irq_request = s.irq_flag & ie_eff & global_irq_enable;
	assign irq_vector = IRQ_VECTOR;
	assign restart_vector = RESET_VECTOR;
	assign dog_reset_pulse = s.dog_reset;

	por_clear_a: assert property ($fell(s.por_flag) |->
		$past(wr_cause) && !$past(io_req.wdata[0]))
		else $error("power-on flag cleared without write");
	flag_set_a: assert property (expire && mode == MODE_IRQ |=>
		s.irq_flag)
		else $error("time-out did not set flag");
	vector_clear_a: assert property (irq_taken && !expire |=>
		!s.irq_flag)
		else $error("vector did not clear flag");
	flag_write_a: assert property (wr_csr && !irq_taken && !expire
		|=> s.irq_flag == ($past(s.irq_flag) && !$past(io_req.wdata[7])))
		else $error("flag write wrong");
	irq_gate_a: assert property (irq_request ==
		(s.irq_flag && csr_view[6] && global_irq_enable))
		else $error("interrupt request gating wrong");
	both_vector_a: assert property (irq_taken && mode == MODE_BOTH
		&& !expire |=> mode == MODE_RESET)
		else $error("combined vector left enable set");
	both_reset_a: assert property (expire && mode == MODE_BOTH
		&& s.irq_flag |=> dog_reset_pulse)
		else $error("unserved time-out gave no reset");
	fuse_mode_a: assert property (fuse_prog |-> mode == MODE_RESET
		&& !csr_view[6] && csr_view[3])
		else $error("fuse did not force reset mode");
	select_lock_a: assert property (wr_csr && !s.cwe
		&& !next_s.dog_reset |=> s.sel == $past(s.sel))
		else $error("select changed outside window");
	window_close_a: assert property (wr_csr && io_req.wdata[4]
		&& io_req.wdata[3] && !next_s.dog_reset
		##1 (!wr_csr && !next_s.dog_reset) [*4] |=>
		!s.cwe && $past(s.cwe) && $past(s.cwe, 4))
		else $error("window length wrong");
	cause_force_a: assert property (s.dog_flag |-> csr_view[3]
		&& mode inside {MODE_RESET, MODE_BOTH})
		else $error("cause flag did not hold reset enable");
	reset_once_a: assert property (dog_reset_pulse |-> s.dog_flag
		##1 !dog_reset_pulse)
		else $error("reset pulse not single");

endmodule // wdt_control
`default_nettype wire

/* wdt_pkg.sv */
// Shared constants and types for the watchdog control block
package wdt_pkg;

	// Register addresses in data space
	localparam logic [7:0]  CSR_ADDR      = 8'h60; // Dog control status
	localparam logic [7:0]  CAUSE_ADDR    = 8'h54; // Reset cause register

	// Field positions of the control status register
	localparam int          IRQ_FLAG_BIT  = 7;     // Time-out interrupt flag
	localparam int          IRQ_EN_BIT    = 6;     // Time-out interrupt enable
	localparam int          SEL_HI_BIT    = 5;     // Select bit 3
	localparam int          CWE_BIT       = 4;     // Change window enable
	localparam int          RE_BIT        = 3;     // Time-out reset enable
	localparam int          SEL_LO_MSB    = 2;     // Select bits 2:0 top

	// Field positions of the reset cause register
	localparam int          POR_BIT       = 0;     // Power-on cause flag
	localparam int          DOG_BIT       = 3;     // Dog reset cause flag

	// Values after reset
	localparam logic [7:0]  CSR_RESET     = 8'h00; // Control status
	localparam logic        POR_RESET     = 1'b1;  // Power-on sets its flag
	localparam logic        FUSE_RESET    = 1'b1;  // Fuse reads unprogrammed

	// Change window length in system clock cycles
	localparam int          CWE_CYCLES    = 4;
	localparam logic [1:0]  CWE_LOAD      = 2'(CWE_CYCLES - 1);

	// Time-out counting in oscillator cycles
	localparam int          OSC_FREQ_HZ   = 128000;   // Dog oscillator
	localparam int          CLK_FREQ_HZ   = 10000000; // System clock
	localparam int          CNT_W         = 21;       // Holds 1024K ticks
	localparam int          BASE_TICKS_DEFAULT = 2048; // Code 0000 period
	localparam logic [3:0]  MAX_CODE      = 4'h9;  // Last defined select

	// Vector addresses
	localparam logic [15:0] RESET_VECTOR  = 16'h0000;
	localparam logic [15:0] IRQ_VECTOR    = 16'h0006;

	// Operating modes, Gray coded along stopped, irq, both, reset
	typedef enum logic [1:0] {
		MODE_STOPPED = 2'h0,
		MODE_IRQ     = 2'h1,
		MODE_BOTH    = 2'h3,
		MODE_RESET   = 2'h2
	} wdt_mode_t;

	// Register access request from the core
	typedef struct packed {
		logic [7:0] addr;  // Data space address
		logic [7:0] wdata; // Write data
		logic       write; // One-cycle write strobe
		logic       read;  // One-cycle read strobe
	} wdt_io_req_t;

endpackage

/* wdt_timeout_counter.sv */
// Time-out counter that counts oscillator ticks up to the selected limit
`timescale 1ns/1ps
`default_nettype none
module wdt_timeout_counter #(
	parameter int               CW         = 21,
	parameter logic [CW-1:0]    BASE_TICKS = 21'h000800
) (
	input  wire logic           ref_clk,
	input  wire logic           reset_n,
	input  wire logic           tick,
	input  wire logic           restart,
	input  wire logic           run,
	input  wire logic [3:0]     select,
	output logic                expire
);
	import wdt_pkg::*;

	// Counter state
	typedef struct packed {
		logic [CW-1:0] cnt;    // Ticks since last restart
		logic          expire; // One-cycle expiry pulse
	} wdt_cnt_state_t;

	wdt_cnt_state_t s;         // Registered state
	wdt_cnt_state_t next_s;    // Next state
	logic [3:0]     eff_code;  // Select with reserved codes folded
	logic [CW-1:0]  limit;     // Ticks per period

	// Next-state logic
	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		// Reserved codes take the longest period, never a shorter one
		eff_code = (select > MAX_CODE) ? MAX_CODE : select;
		limit = BASE_TICKS << eff_code;
		if (restart || !run) begin
			// Restart wins over a tick arriving in the same cycle
			next_s.cnt = '0;
		end else if (tick) begin
			if (s.cnt >= limit - 1'b1) begin
				next_s.cnt = '0;
				next_s.expire = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expire = s.expire;

	// Expiry only follows a tick while running
	expire_cause_a: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		s.expire |-> $past(tick) && $past(run) && !$past(restart))
		else $error("expiry without a tick");

endmodule // wdt_timeout_counter
`default_nettype wire

/* wdt_core_model.sv */
// Core model: dog oscillator source and time-out vector fetch
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       irq_request,
	input  wire logic       serve,
	input  wire logic [3:0] latency,
	output logic            irq_taken,
	output logic            osc_in
);
	logic [3:0] wait_cnt; // Cycles spent before the fetch

	// Free-running dog oscillator, 128 kHz, unrelated to ref_clk
	initial begin
		osc_in = 1'b0;
		forever #3906.25 osc_in = ~osc_in;
	end

	// Fetch the vector after a chosen delay, one pulse per request
	// Never re-arms the enable itself; that is left to later code
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_taken <= 1'b0;
			wait_cnt  <= 4'h0;
		end else begin
			irq_taken <= 1'b0;
			if (serve && irq_request && !irq_taken) begin
				wait_cnt <= (wait_cnt == latency) ? 4'h0 : wait_cnt + 4'h1;
				irq_taken <= (wait_cnt == latency);
			end
		end
	end
endmodule // wdt_core_model
`default_nettype wire

/* wdt_control_test.sv */
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdt_control_test;
	import wdt_pkg::*;
	logic        ref_clk, reset_n, dog_restart, always_on_fuse;
	logic        global_irq_enable, serve, irq_taken, osc_in;
	logic        irq_request, dog_reset_pulse;
	logic [3:0]  latency;      // Core fetch delay
	logic [7:0]  io_rdata;
	logic [15:0] irq_vector, restart_vector;
	wdt_io_req_t io_req;
	int          failures, n_compared, cycles;

	// Short base period keeps every time-out a few hundred clocks
	wdt_control #(.BASE_TICKS(4)) i_wdt_control (.ref_clk(ref_clk),
		.reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
		.osc_in(osc_in), .dog_restart(dog_restart),
		.always_on_fuse(always_on_fuse),
		.global_irq_enable(global_irq_enable), .irq_taken(irq_taken),
		.irq_request(irq_request), .irq_vector(irq_vector),
		.dog_reset_pulse(dog_reset_pulse),
		.restart_vector(restart_vector));
	wdt_core_model i_wdt_core_model (.ref_clk(ref_clk), .reset_n(reset_n),
		.irq_request(irq_request), .serve(serve), .latency(latency),
		.irq_taken(irq_taken), .osc_in(osc_in));

	// System clock, 100 ns period
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Hang guard: a stuck wait ends the run as a failure
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// One-cycle write strobe; an edge passes before the next request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge ref_clk);
		io_req.write <= 1'b0;
	endtask

	// Read data is judged once the registered answer has settled
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
			input string nm);
		@(posedge ref_clk);
		io_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
		@(posedge ref_clk);
		io_req.read <= 1'b0;
		@(posedge ref_clk);
		cmp(nm, {8'h00, e}, {8'h00, io_rdata});
	endtask

	// Bounded wait: 0 request, 1 vector fetch, 2 reset pulse
	task automatic wait_on(input int s, input string nm);
		int n;
		n = 0;
		while (n < 3000 && (s == 0 ? irq_request : s == 1 ? irq_taken
				: dog_reset_pulse) !== 1'b1) begin
			@(posedge ref_clk);
			n++;
		end
		cmp(nm, 16'h0001, {15'h0000, n < 3000});
	endtask

	// Restart instruction clears the count before a mode change
	task automatic kick();
		@(posedge ref_clk);
		dog_restart <= 1'b1;
		@(posedge ref_clk);
		dog_restart <= 1'b0;
	endtask

	task automatic t_reset();
		rd(CSR_ADDR, 8'h00, "csr after reset");
		rd(CAUSE_ADDR, 8'h01, "cause after reset");
		rd(8'h61, 8'h00, "unmapped read");
		cmp("irq vector", 16'h0006, irq_vector);
		cmp("restart vector", 16'h0000, restart_vector);
		$display("test reset done");
	endtask

	// Window opens, self-closes, and guards reset enable and select
	task automatic t_window();
		wr(CSR_ADDR, 8'h18);
		rd(CSR_ADDR, 8'h18, "window open");
		rd(CSR_ADDR, 8'h08, "window closed");
		wr(CSR_ADDR, 8'h00);
		rd(CSR_ADDR, 8'h08, "locked clear");
		wr(CSR_ADDR, 8'h18);
		wr(CSR_ADDR, 8'h20);
		rd(CSR_ADDR, 8'h20, "select high bit");
		wr(CSR_ADDR, 8'h18);
		wr(CSR_ADDR, 8'h01);
		rd(CSR_ADDR, 8'h01, "timed change");
		wr(CSR_ADDR, 8'h02);
		rd(CSR_ADDR, 8'h01, "locked select");
		kick();
		wr(CSR_ADDR, 8'h42);
		rd(CSR_ADDR, 8'h41, "free bits written");
		$display("test window done");
	endtask

	// Interrupt mode: flag, request gating and both ways of clearing
	task automatic t_irq();
		wait_on(0, "request raised");
		rd(CSR_ADDR, 8'hC1, "flag set");
		global_irq_enable <= 1'b0;
		@(posedge ref_clk);
		cmp("gated request", 16'h0000, {15'h0000, irq_request});
		global_irq_enable <= 1'b1;
		wr(CSR_ADDR, 8'h41);
		rd(CSR_ADDR, 8'hC1, "zero keeps flag");
		wr(CSR_ADDR, 8'hC1);
		rd(CSR_ADDR, 8'h41, "one clears flag");
		serve <= 1'b1;
		wait_on(1, "vector fetched");
		serve <= 1'b0;
		rd(CSR_ADDR, 8'h41, "fetch clears flag");
		$display("test irq done");
	endtask

	// Combined mode, then an unserved second time-out resets
	task automatic t_both();
		int t0; // Cycle count between the two time-outs
		kick();
		wr(CSR_ADDR, 8'h49);
		latency <= 4'h5;
		serve <= 1'b1;
		wait_on(1, "slow fetch");
		serve <= 1'b0;
		rd(CSR_ADDR, 8'h09, "fetch drops enable");
		wr(CSR_ADDR, 8'h49);
		wait_on(0, "first time-out");
		t0 = cycles;
		wait_on(2, "second time-out resets");
		// Eight ticks of 128 kHz are 625 clocks; edge sampling blurs a few
		t0 = cycles - t0;
		cmp("period", 16'h0001, {15'h0000, t0 inside {[622:628]}});
		@(posedge ref_clk);
		cmp("pulse width", 16'h0000, {15'h0000, dog_reset_pulse});
		rd(CAUSE_ADDR, 8'h09, "dog cause set");
		rd(CSR_ADDR, 8'h08, "enable forced");
		wr(CSR_ADDR, 8'h18);
		wr(CSR_ADDR, 8'h00);
		rd(CSR_ADDR, 8'h08, "forced despite window");
		wr(CAUSE_ADDR, 8'h01);
		rd(CAUSE_ADDR, 8'h01, "dog cause cleared");
		wr(CSR_ADDR, 8'h18);
		wr(CSR_ADDR, 8'h00);
		rd(CSR_ADDR, 8'h00, "enable cleared");
		wr(CAUSE_ADDR, 8'h00);
		rd(CAUSE_ADDR, 8'h00, "power cause cleared");
		$display("test combined done");
	endtask

	// Programmed fuse forces reset mode whatever the bits say
	task automatic t_fuse();
		always_on_fuse <= 1'b0;
		wr(CSR_ADDR, 8'h40);
		rd(CSR_ADDR, 8'h08, "fuse locks bits");
		wait_on(2, "fuse reset");
		always_on_fuse <= 1'b1;
		wr(CAUSE_ADDR, 8'h00);
		$display("test fuse done");
	endtask

	initial begin
		reset_n = 1'b0;
		io_req = '0;
		dog_restart = 1'b0;
		always_on_fuse = 1'b1;
		global_irq_enable = 1'b1;
		serve = 1'b0;
		latency = 4'h0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_window();
		t_irq();
		t_both();
		t_fuse();
		end_of_test();
	end
endmodule // wdt_control_test
`default_nettype wire
